/* verilog/wdt_pkg.sv */
package wdt_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;

    // Control register layout.
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_PER_LSB  = 1;
    localparam int CTRL_PER_MSB  = 5;

    // Status register layout.
    localparam int STAT_PD_BIT   = 0;
    localparam int STAT_TO_BIT   = 1;
    localparam int STAT_SLP_BIT  = 2;
    localparam int STAT_OST_BIT  = 3;
    localparam int STAT_EN_BIT   = 4;

    // Reset values.
    localparam logic [4:0] PERIOD_RESET = 5'h0b;
    localparam logic       SW_EN_RESET  = 1'b0;

    // Mode field encodings.
    localparam logic [1:0] MODE_OFF      = 2'h0;
    localparam logic [1:0] MODE_SOFTWARE = 2'h1;
    localparam logic [1:0] MODE_NO_SLEEP = 2'h2;
    localparam logic [1:0] MODE_ALWAYS   = 2'h3;

    // Time base: oscillator rate in Hz and the base prescale of code zero.
    localparam int         LFO_RATE_HZ  = 31000;
    localparam int         CNT_W        = 28;
    localparam logic [CNT_W-1:0] PRESCALE_BASE = 28'h0000020;
    localparam logic [4:0] PERIOD_MAX   = 5'h12;

    // Sleep state machine, one-hot.
    typedef enum logic [2:0] {
        ST_AWAKE  = 3'h1,
        ST_ASLEEP = 3'h2,
        ST_HOLD   = 3'h4
    } sleep_state_t;

endpackage

/* verilog/lfo_tick_detect.sv */
`timescale 1ns/100ps
module lfo_tick_detect (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic low_freq_osc,
    output logic      tick
);

    logic lfo_d_r;

    // One pulse per rising edge of the slow oscillator.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfo_d_r <= 1'b0;
            tick    <= 1'b0;
        end else begin
            lfo_d_r <= low_freq_osc;
            tick    <= low_freq_osc & ~lfo_d_r;
        end
    end

endmodule

/* verilog/wdt_prescaler.sv */
`timescale 1ns/100ps
module wdt_prescaler (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       tick,
    input  wire logic       clear,
    input  wire logic [4:0] period_sel,
    output logic            expire
);

    logic [wdt_pkg::CNT_W-1:0] count_r;

    // Terminal count in oscillator ticks; reserved codes use the shortest.
    // reserved codes fold.
    function automatic logic [wdt_pkg::CNT_W-1:0] terminal(input logic [4:0] sel);
        if (sel > wdt_pkg::PERIOD_MAX) begin
            terminal = wdt_pkg::PRESCALE_BASE;
        end else begin
            terminal = wdt_pkg::PRESCALE_BASE << sel;
        end
    endfunction

    // Clear dominates the tick so a held clear keeps the count at zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= '0;
            expire  <= 1'b0;
        end else begin
            expire <= 1'b0;
            if (clear) begin
                count_r <= '0;
            end else if (tick) begin
                if (count_r >= terminal(period_sel) - 1'b1) begin
                    count_r <= '0;
                    expire  <= 1'b1;
                end else begin
                    count_r <= count_r + 1'b1;
                end
            end
        end
    end

endmodule

/* verilog/wdt_top.sv */
`timescale 1ns/100ps
module wdt_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  wdt_mode_sel,
    input  wire logic        low_freq_osc,
    input  wire logic        wdt_clear_instr,
    input  wire logic        sleep_enter,
    input  wire logic        wake_event,
    input  wire logic        osc_fail,
    input  wire logic        clock_is_crystal,
    input  wire logic        osc_startup_timer,
    output logic             wdt_reset_req,
    output logic             wdt_wake,
    output logic             asleep,
    output logic             timeout_flag_n,
    output logic             powerdown_flag_n
);

    wdt_pkg::sleep_state_t state_r;
    wdt_pkg::sleep_state_t state_nxt;

    logic [4:0] wdt_period_sel_r;
    logic       sw_wdt_enable_r;
    logic       tick;
    logic       expire;
    logic       wdt_active;
    logic       count_clear;
    logic       exit_sleep;
    logic       wr_ctrl;
    logic       access;
    logic       in_sleep;
    logic       in_hold;
    logic       sleep_entry;
    logic       setup_phase;

    // Address decode, used by both the write and the read paths.
    function automatic logic [1:0] decode(input logic [7:0] addr);
        if (addr == wdt_pkg::CTRL_OFFSET) begin
            decode = 2'h1;
        end else if (addr == wdt_pkg::STATUS_OFFSET) begin
            decode = 2'h2;
        end else begin
            decode = 2'h0;
        end
    endfunction

    // Shared state decodes, read by the timeout routing, the power-down flag and the
    // status read; the run decision, exit_sleep and count_clear still test state_r directly.
    assign in_sleep    = (state_r == wdt_pkg::ST_ASLEEP);
    assign in_hold     = (state_r == wdt_pkg::ST_HOLD);

    // A sleep request counts only while awake; one that arrives during the
    // start-up hold is dropped, since the core has not resumed by then.
    assign sleep_entry = sleep_enter && (state_r == wdt_pkg::ST_AWAKE);

    // Setup cycle of an APB transfer, in which the answer is prepared.
    assign setup_phase = psel && !penable;

    lfo_tick_detect u_tick (
        .pclk         (pclk),
        .presetn      (presetn),
        .low_freq_osc (low_freq_osc),
        .tick         (tick)
    );

    // reserved codes shortest.
    // Reserved codes fold inside the prescaler, so software never sees a hang.
    wdt_prescaler u_prescale (
        .pclk       (pclk),
        .presetn    (presetn),
        .tick       (tick),
        .clear      (count_clear),
        .period_sel (wdt_period_sel_r),
        .expire     (expire)
    );

    // Run decision from the mode field, software enable and sleep state.
    always_comb begin
        case (wdt_mode_sel)
            wdt_pkg::MODE_ALWAYS: begin
                wdt_active = 1'b1;
            end
            wdt_pkg::MODE_NO_SLEEP: begin
                wdt_active = (state_r != wdt_pkg::ST_ASLEEP);
            end
            wdt_pkg::MODE_SOFTWARE: begin
                wdt_active = sw_wdt_enable_r;
            end
            default: begin
                wdt_active = 1'b0;
            end
        endcase
    end
    // modes 1x never look at sw_wdt_enable_r above.

    // Sleep ends on any wake source or on our own timeout while asleep.
    assign exit_sleep = (state_r == wdt_pkg::ST_ASLEEP) && (wake_event || expire);

    // every clearing condition feeds one clear.
    // the divider select is not an input, so it cannot clear.
    assign count_clear = wdt_clear_instr
                       | (sleep_enter && state_r == wdt_pkg::ST_AWAKE)
                       | exit_sleep
                       | osc_fail
                       | ~wdt_active
                       | (state_r == wdt_pkg::ST_HOLD);

    // Sleep state transitions.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            wdt_pkg::ST_AWAKE: begin
                if (sleep_enter) begin
                    state_nxt = wdt_pkg::ST_ASLEEP;
                end
            end
            wdt_pkg::ST_ASLEEP: begin
                if (exit_sleep) begin
                    if (clock_is_crystal) begin
                        state_nxt = wdt_pkg::ST_HOLD;
                    end else begin
                        state_nxt = wdt_pkg::ST_AWAKE;
                    end
                end
            end
            wdt_pkg::ST_HOLD: begin
                if (!osc_startup_timer) begin
                    state_nxt = wdt_pkg::ST_AWAKE;
                end
            end
            default: begin
                state_nxt = wdt_pkg::ST_AWAKE;
            end
        endcase
    end

    // Sleep state register; the asleep output mirrors it from a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= wdt_pkg::ST_AWAKE;
            asleep  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            asleep  <= (state_nxt == wdt_pkg::ST_ASLEEP);
        end
    end
    // the entry clear leaves the counter at zero; it then runs on in MODE_ALWAYS, or in MODE_SOFTWARE when enabled.

    // Timeout routing: reset when awake, wake when asleep. Each event is a
    // registered copy of the single-cycle expire, so neither can stretch.
    // one-cycle event.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_reset_req <= 1'b0;
        end else begin
            wdt_reset_req <= expire && !in_sleep;
        end
    end

    // The count is held clear in the start-up hold, so a timeout can only
    // meet the awake or asleep state; asleep is the one state that wakes instead.
    // sleep timeout wakes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_wake <= 1'b0;
        end else begin
            wdt_wake <= expire && in_sleep;
        end
    end

    // Timeout flag, active low. A timeout in the same cycle as a clear
    // instruction or a sleep entry wins, so the event is never lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_flag_n <= 1'b1;
        end else begin
            if (expire) begin
                timeout_flag_n <= 1'b0;
            end else if (sleep_entry) begin
                timeout_flag_n <= 1'b1;
            end else if (wdt_clear_instr) begin
                timeout_flag_n <= 1'b1;
            end
        end
    end

    // Power-down flag, active low. It stays low through a sleep timeout so
    // that software can tell a watchdog wake from an awake watchdog reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            powerdown_flag_n <= 1'b1;
        end else begin
            if (expire) begin
                if (!in_sleep) begin
                    powerdown_flag_n <= 1'b1;
                end
            end else if (sleep_entry) begin
                powerdown_flag_n <= 1'b0;
            end else if (wdt_clear_instr) begin
                powerdown_flag_n <= 1'b1;
            end
        end
    end

    // Control register writes take effect at the completing access edge.
    assign access  = psel && penable && pready;
    assign wr_ctrl = access && pwrite && (decode(paddr) == 2'h1);

    // reset values of the control fields.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_period_sel_r <= wdt_pkg::PERIOD_RESET;
            sw_wdt_enable_r  <= wdt_pkg::SW_EN_RESET;
        end else if (wr_ctrl) begin
            wdt_period_sel_r <= pwdata[wdt_pkg::CTRL_PER_MSB:wdt_pkg::CTRL_PER_LSB];
            sw_wdt_enable_r  <= pwdata[wdt_pkg::CTRL_EN_BIT];
        end
    end

    // APB answer: ready, data and error are prepared during the setup cycle,
    // giving a zero-wait access phase while every output stays a flop. The
    // price is that a read returns the state of the setup cycle, one clock
    // older than the access edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_phase;
        end
    end

    // Unmapped offsets answer with an error and read as zero; writes to them
    // are dropped by the decode in the control write path.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup_phase && (decode(paddr) == 2'h0);
        end
    end

    // Read data is zero outside a read, so no stale value lingers on the bus.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else begin
            prdata <= '0;
            if (setup_phase && !pwrite) begin
                if (decode(paddr) == 2'h1) begin
                    prdata[wdt_pkg::CTRL_PER_MSB:wdt_pkg::CTRL_PER_LSB] <= wdt_period_sel_r;
                    prdata[wdt_pkg::CTRL_EN_BIT] <= sw_wdt_enable_r;
                end else if (decode(paddr) == 2'h2) begin
                    // Status bits mirror both flags and the sleep state machine.
                    prdata[wdt_pkg::STAT_PD_BIT]  <= powerdown_flag_n;
                    prdata[wdt_pkg::STAT_TO_BIT]  <= timeout_flag_n;
                    prdata[wdt_pkg::STAT_SLP_BIT] <= in_sleep;
                    prdata[wdt_pkg::STAT_OST_BIT] <= in_hold;
                    prdata[wdt_pkg::STAT_EN_BIT]  <= wdt_active;
                end
            end
        end
    end

endmodule

/* bench/wdt_monitor.sv */
`timescale 1ns/100ps
module wdt_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  wdt_mode_sel,
    input wire logic        wdt_reset_req,
    input wire logic        wdt_wake,
    input wire logic        asleep,
    input wire logic        timeout_flag_n,
    input wire logic        powerdown_flag_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bus phases; the access is only judged at its completing edge.
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence done_s;
        psel && penable && pready;
    endsequence

    ready_zero_a: assert property (setup_s |=> pready)
        else $error("pready not one cycle after setup");
    unmapped_err_a: assert property (done_s ##0 (paddr != 8'h00 && paddr != 8'h04) |-> pslverr)
        else $error("unmapped access without pslverr");
    ctrl_upper_a: assert property (done_s ##0 (!pwrite && paddr == 8'h00) |-> !(|prdata[31:6]))
        else $error("control upper bits not zero");
    reset_pulse_a: assert property (wdt_reset_req |=> !wdt_reset_req)
        else $error("reset request longer than one cycle");
    wake_pulse_a: assert property ($rose(wdt_wake) |=> !wdt_wake)
        else $error("wake longer than one cycle");
    off_quiet_a: assert property (wdt_mode_sel == 2'h0 |-> !(wdt_reset_req || wdt_wake))
        else $error("timeout in off mode");
    sleep_noreset_a: assert property (asleep && $past(asleep) |-> !wdt_reset_req)
        else $error("reset request while asleep");
    nosleep_quiet_a: assert property (asleep && wdt_mode_sel == 2'h2 |=> !wdt_wake)
        else $error("wake in mode off-in-sleep");
    entry_flags_a: assert property ($rose(asleep) |-> !powerdown_flag_n && timeout_flag_n)
        else $error("flags wrong on sleep entry");
    wake_flags_a: assert property (wdt_wake |-> !timeout_flag_n && !powerdown_flag_n)
        else $error("flags wrong on sleep timeout");
    awake_flags_a: assert property (wdt_reset_req |-> !timeout_flag_n && powerdown_flag_n)
        else $error("flags wrong on awake timeout");
endmodule

bind wdt_top wdt_monitor u_wdt_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .wdt_mode_sel, .wdt_reset_req, .wdt_wake, .asleep,
    .timeout_flag_n, .powerdown_flag_n);

/* bench/test_watchdog_timer_four_mode.sv */
`timescale 1ns/100ps
module test_watchdog_timer_four_mode;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [1:0]  wdt_mode_sel = 2'h0;
    logic        low_freq_osc = 1'b0;
    logic [3:0]  pulses = 4'h0; // Wake, sleep entry, clear, oscillator fail.
    logic        clock_is_crystal = 1'b0;
    logic        osc_startup_timer = 1'b0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, wdt_reset_req, wdt_wake, asleep;
    logic        timeout_flag_n, powerdown_flag_n;
    int          n_mismatch = 0, num_checks = 0, n_rst, n_wk, cyc = 0, seed = 73;
    int          codes[3];

    wdt_top u_wdt_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .wdt_mode_sel, .low_freq_osc,
        .wdt_clear_instr(pulses[1]), .sleep_enter(pulses[2]), .wake_event(pulses[3]),
        .osc_fail(pulses[0]), .clock_is_crystal, .osc_startup_timer, .wdt_reset_req,
        .wdt_wake, .asleep, .timeout_flag_n, .powerdown_flag_n);

    // Free-running bus clock; pulse counters and the hang guard share it.
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        n_rst += (wdt_reset_req === 1'b1);
        n_wk += (wdt_wake === 1'b1);
        cyc++;
        if (cyc > 60000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test();
        if (n_mismatch == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // The request is held until pready is sampled high; no wait count is assumed.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Mode is a configuration input, so it only changes under reset.
    task automatic rst(input logic [1:0] m);
        @(posedge pclk);
        presetn <= 1'b0;
        wdt_mode_sel <= m;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // Gives n slow rising edges, eight bus cycles apart, then lets pulses land.
    task automatic go(input int n);
        n_rst = 0;
        n_wk = 0;
        repeat (2 * n) begin
            repeat (4) @(posedge pclk);
            low_freq_osc <= ~low_freq_osc;
        end
        repeat (6) @(posedge pclk);
    endtask

    task automatic pul(input int k);
        @(posedge pclk);
        pulses <= 4'h1 << k;
        @(posedge pclk);
        pulses <= 4'h0;
        repeat (2) @(posedge pclk);
    endtask

    // Reference model: whether the count runs for a mode, enable and sleep state.
    function automatic int runs(input int m, input int en, input int slp);
        return (m == 3 || (m == 2 && slp == 0) || (m == 1 && en == 1)) ? 1 : 0;
    endfunction

    initial begin
        rst(2'h0);
        apb(1'b0, wdt_pkg::CTRL_OFFSET, 32'h0);
        chk("ctrl_reset", rd, {26'h0, wdt_pkg::PERIOD_RESET, wdt_pkg::SW_EN_RESET});
        apb(1'b1, wdt_pkg::CTRL_OFFSET, 32'hffffffff);
        apb(1'b0, wdt_pkg::CTRL_OFFSET, 32'h0);
        chk("ctrl_rw", rd, 32'h3f);
        apb(1'b0, 8'h08, 32'h0);
        chk("unmapped", {err, rd[30:0]}, 32'h80000000);
        // every mode with both enable values.
        for (int m = 0; m < 4; m++) begin
            for (int en = 0; en < 2; en++) begin
                rst(m[1:0]);
                apb(1'b1, wdt_pkg::CTRL_OFFSET, 32'(en));
                go(31);
                chk("early", n_rst, 0);
                go(1);
                chk("mode", n_rst, runs(m, en, 0));
            end
        end
        n_rst = 0;
        repeat (400) @(posedge pclk);
        chk("bus_clock_only", n_rst, 0);
        // periods, one reserved code chosen at random.
        codes = '{1, 2, 19 + ({$random(seed)} % 13)};
        foreach (codes[i]) begin
            rst(2'h3);
            apb(1'b1, wdt_pkg::CTRL_OFFSET, 32'(codes[i] * 2));
            go(((codes[i] > 18) ? 32 : (32 << codes[i])) - 1);
            chk("before_end", n_rst, 0);
            go(1);
            chk("period", n_rst, 1);
        end
        // oscillator fail and clear instruction restart the count.
        for (int k = 0; k < 2; k++) begin
            rst(2'h3);
            apb(1'b1, wdt_pkg::CTRL_OFFSET, 32'h0);
            go(20);
            pul(k);
            go(31);
            chk("cleared", n_rst, 0);
            go(1);
            chk("after_clear", n_rst, 1);
        end
        rst(2'h3);
        apb(1'b1, wdt_pkg::CTRL_OFFSET, 32'h0);
        go(20);
        pul(2);
        chk("entry_flags", {asleep, timeout_flag_n, powerdown_flag_n}, 3'b110);
        go(31);
        chk("sleep_early", n_wk, 0);
        go(1);
        chk("sleep_wake", n_wk * 2 + n_rst, 2);
        chk("wake_flags", {asleep, timeout_flag_n, powerdown_flag_n}, 3'b000);
        apb(1'b0, wdt_pkg::STATUS_OFFSET, 32'h0);
        chk("wake_status", rd, 32'h10);
        // no watchdog while asleep in mode 10.
        rst(2'h2);
        apb(1'b1, wdt_pkg::CTRL_OFFSET, 32'h0);
        pul(2);
        go(40);
        chk("m2_sleep", n_wk + n_rst, 0);
        pul(3);
        go(32);
        chk("m2_awake", n_rst, 1);
        // crystal wake holds the count until start-up ends.
        rst(2'h3);
        clock_is_crystal <= 1'b1;
        osc_startup_timer <= 1'b1;
        apb(1'b1, wdt_pkg::CTRL_OFFSET, 32'h0);
        pul(2);
        pul(3);
        apb(1'b0, wdt_pkg::STATUS_OFFSET, 32'h0);
        chk("hold_status", rd, 32'h1a);
        go(40);
        chk("ost_hold", n_rst, 0);
        osc_startup_timer <= 1'b0;
        go(32);
        chk("ost_done", n_rst, 1);
        finish_test();
    end
endmodule
